/* File: src/srg_pkg.sv */
// Purpose: shared constants for the supervisor reset gate and backup control
// Assumes: 25 MHz system clock
// Notes:   timing figures kept in their own unit, cycle counts derived
package srg_pkg;
   // ==========================================================
   // clock
   localparam int unsigned CLK_HZ          = 25_000_000;
   localparam int unsigned CLK_NS          = 40;
   // ==========================================================
   // nominal times
   localparam int unsigned WD_LONG_MS      = 1600;
   localparam int unsigned WD_SHORT_MS     = 100;
   localparam int unsigned RST_MS          = 200;
   localparam int unsigned CE_HOLD_US      = 12;
   localparam int unsigned KICK_MIN_NS     = 100;
   // ==========================================================
   // timebase: one tick per millisecond of internal oscillator
   localparam int unsigned TICK_CYC        = CLK_HZ / 1000;
   // external timebase clock counts
   localparam int unsigned EXT_WD_NORM     = 1024;
   localparam int unsigned EXT_WD_FIRST    = 4096;
   localparam int unsigned EXT_RST         = 2048;
   // ce hold, longest time: round down
   localparam int unsigned CE_HOLD_CYC     = (CE_HOLD_US * 1000) / CLK_NS;
   // kick minimum, least time: round up
   localparam int unsigned KICK_MIN_CYC    =
      (KICK_MIN_NS + CLK_NS - 1) / CLK_NS;
   // ==========================================================
   // reset values of outputs
   localparam logic        RST_CE_OUT      = 1'b1;
   localparam logic        RST_WDO         = 1'b1;
   // ==========================================================
   // states of the reset sequencer
   typedef enum logic [2:0] {
      SRG_ST_LOW  = 3'b001,
      SRG_ST_HOLD = 3'b010,
      SRG_ST_RUN  = 3'b100
   } srg_state_t;
endpackage

/* File: src/srg_sync.sv */
// Purpose: two-stage synchroniser for a bank of comparator levels
// Assumes: single clock, synchronous reset
// Notes:   first stage feeds only the second
`timescale 1ns/100ps
module srg_sync
#(
   parameter int unsigned W = 4
)
(
   input  wire logic         i_sys_clk,
   input  wire logic         i_rst,
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);
   // ==========================================================
   // two flops per bit; each bit owns its pair, one writer each
   genvar g;
   generate
      for (g = 0; g < W; g = g + 1)
      begin : g_bit
         logic s1_r;
         logic s2_r;
         always_ff @(posedge i_sys_clk)
         begin
            if (i_rst)
            begin
               s1_r <= 1'b0;
               s2_r <= 1'b0;
            end
            else
            begin
               s1_r <= i_d[g];
               s2_r <= s1_r;
            end
         end
         assign o_q[g] = s2_r;
      end
   endgenerate
endmodule

/* File: src/srg_top.sv */
// Purpose: supervisor digital core: timeouts, chip-select gate, flags
// Assumes: comparator results arrive as levels; one 25 MHz clock
// Notes:   analog switch and current limits live outside
//
// Functional notes
// - both straps high: 1.6s watchdog, 200ms reset pulse.
// - timebase low, select high: 100ms watchdog, 1.6s first after reset.
// - short watchdog setting keeps reset pulse at 200ms.
// - select strap low: periods come from the external timebase clock.
// - chip-select gate passes input normally, disabled during reset once the hold window closes.
// - chip-select input goes high impedance whenever the gate is disabled or backup mode is on.
// - power-down disable at input high or 12us after reset, earlier wins.
// - on power-up chip-select stays disabled until reset deasserts.
// - disabled gate drives chip-select output high; released when enabled.
// - supply-low flag copies reset comparator: high above threshold.
// - early fail flag low when sense below reference, else high.
// - backup mode only when supply below threshold and below battery.
// - backup flag high when supply below battery, else low.
// - backup mode ignores kick and straps, holding them high impedance.
// - backup mode disables early fail compare and forces flag low.
// - backup mode forces listed output levels and high impedance pins.
// - other side toggles kick at least 100ns each period; restarts timer.
// - on expiry watchdog output goes low until next kick edge or supply loss.
// - without kicks, reset pulses repeat once per first-after-reset watchdog period.
// - resets assert while supply low, hold reset timeout after recovery.
`timescale 1ns/100ps
module srg_top
#(
   parameter int unsigned WD_LONG_TICKS  = srg_pkg::WD_LONG_MS,
   parameter int unsigned WD_SHORT_TICKS = srg_pkg::WD_SHORT_MS,
   parameter int unsigned RST_TICKS      = srg_pkg::RST_MS,
   parameter int unsigned TICK_CYC       = srg_pkg::TICK_CYC
)
(
   input  wire logic i_sys_clk,
   input  wire logic i_rst,
   input  wire logic i_supply_ok,
   input  wire logic i_supply_above_batt,
   input  wire logic i_early_fail_sense_ok,
   input  wire logic i_timebase_select_strap,
   input  wire logic i_timebase_input,
   input  wire logic i_watchdog_kick_in,
   input  wire logic i_watchdog_kick_float,
   input  wire logic i_chip_select_in_n,
   output logic      o_chip_select_out_n,
   output logic      o_chip_select_in_en,
   output logic      o_reset_n,
   output logic      o_reset_od_o,
   output logic      o_reset_od_oe,
   output logic      o_supply_low_flag_n,
   output logic      o_early_fail_flag_n,
   output logic      o_backup_active_flag,
   output logic      o_watchdog_expired_out_n,
   output logic      o_inputs_hiz
);
   // ==========================================================
   // synchronised comparator levels and pins
   logic [5:0] sy;
   logic       sup_ok;
   logic       above_batt;
   logic       pf_ok;
   logic       timebase_select_strap;
   logic       timebase_input;
   logic       kick;
   srg_sync #(.W(6)) u_sync
   (
      .i_sys_clk (i_sys_clk),
      .i_rst     (i_rst),
      .i_d       ({i_supply_ok, i_supply_above_batt,
                   i_early_fail_sense_ok, i_timebase_select_strap,
                   i_timebase_input, i_watchdog_kick_in}),
      .o_q       (sy)
   );
   assign sup_ok     = sy[5];
   assign above_batt = sy[4];
   assign pf_ok      = sy[3];
   assign timebase_select_strap    = sy[2];
   assign timebase_input     = sy[1];
   assign kick       = sy[0];

   logic backup;
   assign backup = !sup_ok && !above_batt;
   // ==========================================================
   // timebase: internal ms tick or external clock edge
   logic        ext_mode;
   logic        short_mode;
   logic [15:0] div_r;
   logic        osc_d_r;
   logic        tick;
   assign ext_mode   = !timebase_select_strap;
   assign short_mode = timebase_select_strap && !timebase_input;
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         div_r   <= 16'h0000;
         osc_d_r <= 1'b0;
      end
      else
      begin
         osc_d_r <= timebase_input;
         if (div_r == 16'(TICK_CYC - 1))
            div_r <= 16'h0000;
         else
            div_r <= div_r + 16'h0001;
      end
   end
   assign tick = ext_mode ? (timebase_input && !osc_d_r)
                          : (div_r == 16'(TICK_CYC - 1));
   // ==========================================================
   // selected periods in ticks
   logic [15:0] wd_norm;
   logic [15:0] wd_first;
   logic [15:0] rst_len;
   always_comb
   begin
      if (ext_mode)
      begin
         wd_norm  = 16'(srg_pkg::EXT_WD_NORM);
         wd_first = 16'(srg_pkg::EXT_WD_FIRST);
         rst_len  = 16'(srg_pkg::EXT_RST);
      end
      else if (short_mode)
      begin
         wd_norm  = 16'(WD_SHORT_TICKS);
         wd_first = 16'(WD_LONG_TICKS);
         rst_len  = 16'(RST_TICKS);
      end
      else
      begin
         wd_norm  = 16'(WD_LONG_TICKS);
         wd_first = 16'(WD_LONG_TICKS);
         rst_len  = 16'(RST_TICKS);
      end
   end
   // ==========================================================
   // kick qualification: level must hold the minimum width
   logic       kick_st_r;
   logic [1:0] kick_cnt_r;
   logic       kick_edge;
   assign kick_edge = (kick != kick_st_r)
                      && (kick_cnt_r == 2'(srg_pkg::KICK_MIN_CYC - 1))
                      && !i_watchdog_kick_float && !backup;
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         kick_st_r  <= 1'b0;
         kick_cnt_r <= 2'b00;
      end
      else if (kick == kick_st_r)
         kick_cnt_r <= 2'b00;
      else if (kick_edge)
      begin
         kick_st_r  <= kick;
         kick_cnt_r <= 2'b00;
      end
      else
         kick_cnt_r <= kick_cnt_r + 2'b01;
   end
   // ==========================================================
   // reset sequencer
   srg_pkg::srg_state_t st_r;
   logic [15:0]         rcnt_r;
   logic                wd_fire;
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         st_r   <= srg_pkg::SRG_ST_LOW;
         rcnt_r <= 16'h0000;
      end
      else if (!sup_ok)
      begin
         st_r   <= srg_pkg::SRG_ST_LOW;
         rcnt_r <= 16'h0000;
      end
      else
      begin
         case (st_r)
            srg_pkg::SRG_ST_LOW:
            begin
               st_r   <= srg_pkg::SRG_ST_HOLD;
               rcnt_r <= 16'h0000;
            end
            srg_pkg::SRG_ST_HOLD:
            begin
               if (tick)
               begin
                  if (rcnt_r >= rst_len - 16'h0001)
                     st_r <= srg_pkg::SRG_ST_RUN;
                  else
                     rcnt_r <= rcnt_r + 16'h0001;
               end
            end
            srg_pkg::SRG_ST_RUN:
            begin
               if (wd_fire)
               begin
                  st_r   <= srg_pkg::SRG_ST_HOLD;
                  rcnt_r <= 16'h0000;
               end
            end
            default:
               st_r <= srg_pkg::SRG_ST_LOW;
         endcase
      end
   end
   logic rst_act;
   assign rst_act = (st_r != srg_pkg::SRG_ST_RUN);
   // ==========================================================
   // watchdog counter
   logic [15:0] wcnt_r;
   logic        first_r;
   logic        wd_lim_hit;
   assign wd_lim_hit = tick &&
      (wcnt_r >= (first_r ? wd_first : wd_norm) - 16'h0001);
   assign wd_fire = (st_r == srg_pkg::SRG_ST_RUN) && wd_lim_hit
                    && !kick_edge && !i_watchdog_kick_float;
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst || rst_act || kick_edge)
      begin
         wcnt_r <= 16'h0000;
      end
      else if (tick)
         wcnt_r <= wcnt_r + 16'h0001;
   end
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst || rst_act)
         first_r <= 1'b1;
      else if (kick_edge || wd_fire)
         first_r <= 1'b0;
   end
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
         o_watchdog_expired_out_n <= srg_pkg::RST_WDO;
      else if (!sup_ok || kick_edge)
         o_watchdog_expired_out_n <= 1'b1;
      else if (wd_fire)
         o_watchdog_expired_out_n <= 1'b0;
   end
   // ==========================================================
   // chip-select gate; hold window lets a write finish
   logic [8:0] ce_cnt_r;
   logic       gate_en_r;
   logic       rst_act_d_r;
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         gate_en_r   <= 1'b0;
         ce_cnt_r    <= 9'h000;
         rst_act_d_r <= 1'b1;
      end
      else
      begin
         rst_act_d_r <= rst_act;
         if (!rst_act)
            gate_en_r <= 1'b1;
         else if (!rst_act_d_r)
         begin
            // reset just asserted; close now if input already high
            gate_en_r <= !i_chip_select_in_n;
            ce_cnt_r  <= 9'h000;
         end
         else if (gate_en_r)
         begin
            ce_cnt_r <= ce_cnt_r + 9'h001;
            if (i_chip_select_in_n ||
                ce_cnt_r >= 9'(srg_pkg::CE_HOLD_CYC - 1))
               gate_en_r <= 1'b0;
         end
      end
   end
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         o_chip_select_out_n <= srg_pkg::RST_CE_OUT;
         o_chip_select_in_en <= 1'b0;
      end
      else
      begin
         // registered pass: one cycle of latency traded for a clean output
         o_chip_select_out_n <= gate_en_r && !backup
                                ? i_chip_select_in_n : 1'b1;
         o_chip_select_in_en <= gate_en_r && !backup;
      end
   end
   // ==========================================================
   // flags and reset pins
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         o_reset_n            <= 1'b0;
         o_reset_od_o         <= 1'b0;
         o_reset_od_oe        <= 1'b0;
         o_supply_low_flag_n  <= 1'b0;
         o_early_fail_flag_n  <= 1'b0;
         o_backup_active_flag <= 1'b0;
         o_inputs_hiz         <= 1'b0;
      end
      else
      begin
         o_reset_n            <= !rst_act;
         o_reset_od_o         <= 1'b0;
         // open drain high output: floats when reset asserted
         o_reset_od_oe        <= !rst_act && !backup;
         o_supply_low_flag_n  <= sup_ok;
         o_early_fail_flag_n  <= pf_ok && !backup;
         o_backup_active_flag <= !above_batt;
         o_inputs_hiz         <= backup;
      end
   end
   // ==========================================================
   // checks
   property p_wdo_low_hold;
      @(posedge i_sys_clk) disable iff (i_rst)
      (wd_fire && sup_ok) |=> !o_watchdog_expired_out_n;
   endproperty
   a_wdo_low_hold: assert property (p_wdo_low_hold)
      else $error("watchdog output not low after expiry");

   property p_reset_on_low;
      @(posedge i_sys_clk) disable iff (i_rst)
      !sup_ok |=> ##1 !o_reset_n;
   endproperty
   a_reset_on_low: assert property (p_reset_on_low)
      else $error("reset not asserted on low supply");

   property p_ce_high_in_reset;
      @(posedge i_sys_clk) disable iff (i_rst)
      (!gate_en_r) |=> o_chip_select_out_n && !o_chip_select_in_en;
   endproperty
   a_ce_high_in_reset: assert property (p_ce_high_in_reset)
      else $error("chip select not forced high while disabled");

   property p_pfo_backup;
      @(posedge i_sys_clk) disable iff (i_rst)
      backup |=> !o_early_fail_flag_n;
   endproperty
   a_pfo_backup: assert property (p_pfo_backup)
      else $error("early fail flag not low in backup");

   property p_supply_low_flag;
      @(posedge i_sys_clk) disable iff (i_rst)
      1'b1 |=> (o_supply_low_flag_n == $past(sup_ok));
   endproperty
   a_supply_low_flag: assert property (p_supply_low_flag)
      else $error("supply low flag mismatch");

   property p_batt;
      @(posedge i_sys_clk) disable iff (i_rst)
      1'b1 |=> (o_backup_active_flag == !$past(above_batt));
   endproperty
   a_batt: assert property (p_batt)
      else $error("backup flag mismatch");

   property p_cein_hiz;
      @(posedge i_sys_clk) disable iff (i_rst)
      (rst_act && rst_act_d_r && !gate_en_r) |=> !o_chip_select_in_en;
   endproperty
   a_cein_hiz: assert property (p_cein_hiz)
      else $error("chip select input enabled during reset");

   property p_kick_restart;
      @(posedge i_sys_clk) disable iff (i_rst)
      (kick_edge && !rst_act) |=> (wcnt_r == 16'h0000);
   endproperty
   a_kick_restart: assert property (p_kick_restart)
      else $error("kick did not restart watchdog");
endmodule

/* File: tb/srg_host_model.sv */
// Purpose: processor side: kicks the watchdog, drives memory select
// Assumes: commands from the bench change at the falling edge
// Notes:   kick level held 4 cycles, well over the 100ns floor
`timescale 1ns/100ps
module srg_host_model
(
   input  wire logic i_sys_clk,
   input  wire logic i_kick_en,
   input  wire logic i_cs_req,
   output logic      o_kick,
   output logic      o_cs_n
);
   logic [1:0] div_r;

   initial
   begin
      div_r  = 2'h0;
      o_kick = 1'b0;
      o_cs_n = 1'b1;
   end

   // ==========================================================
   // kick and select, both launched off the falling edge
   always @(negedge i_sys_clk)
   begin
      div_r  <= div_r + 2'h1;
      o_cs_n <= ~i_cs_req;
      if (i_kick_en && div_r == 2'h3)
         o_kick <= ~o_kick;
   end
endmodule

/* File: tb/test_srg_top.sv */
// Purpose: self-checking bench for the supervisor digital core
// Assumes: shortened tick counts, 25 MHz clock
// Notes:   driver queues expected levels, a monitor judges them
`timescale 1ns/100ps
module test_srg_top;
   localparam int TCK  = 10;
   localparam int LNG  = 16 * TCK;
   localparam int SHT  = 4 * TCK;
   localparam int RSTC = 2 * TCK;
   localparam int CEO = 0, EN = 1, RSN = 2, ODOE = 3, SL = 4;
   localparam int EF = 5, BK = 6, WATCHDOG_EXPIRED_OUT = 7, HIZ = 8, ODO = 9;
   localparam int EXT = 4 * srg_pkg::EXT_RST;
   typedef struct {int idx; logic v;} srg_note_t;

   srg_note_t   q[$];
   srg_note_t   nt;
   string       nm[10] = '{"ce_out_n", "ce_in_en", "reset_n", "od_oe",
      "supply_low_n", "early_fail_n", "backup", "wdo_n", "hiz", "od_o"};
   event        sample_ev;
   int          num_errors, n_checks, seed, n, r;
   logic        clk, rst, sup_ok, abv_bat, pf_ok, sel, tbase;
   logic        ext_run, ext_ph, ext_clk, kfl, kick_en, cs_req;
   logic        kick, cs_n, ceo, en, rsn, odo, odoe, sl, ef, bk, watchdog_expired_out, hiz;
   logic [9:0]  obs;

   assign obs = {odo, hiz, watchdog_expired_out, bk, ef, sl, odoe, rsn, en, ceo};

   srg_top #(.WD_LONG_TICKS(16), .WD_SHORT_TICKS(4), .RST_TICKS(2),
      .TICK_CYC(TCK)) dut
   (
      .i_sys_clk               (clk),
      .i_rst                   (rst),
      .i_supply_ok             (sup_ok),
      .i_supply_above_batt     (abv_bat),
      .i_early_fail_sense_ok   (pf_ok),
      .i_timebase_select_strap (sel),
      .i_timebase_input        (ext_run ? ext_clk : tbase),
      .i_watchdog_kick_in      (kick),
      .i_watchdog_kick_float   (kfl),
      .i_chip_select_in_n      (cs_n),
      .o_chip_select_out_n     (ceo),
      .o_chip_select_in_en     (en),
      .o_reset_n               (rsn),
      .o_reset_od_o            (odo),
      .o_reset_od_oe           (odoe),
      .o_supply_low_flag_n     (sl),
      .o_early_fail_flag_n     (ef),
      .o_backup_active_flag    (bk),
      .o_watchdog_expired_out_n(watchdog_expired_out),
      .o_inputs_hiz            (hiz)
   );

   srg_host_model host
   (
      .i_sys_clk (clk),
      .i_kick_en (kick_en),
      .i_cs_req  (cs_req),
      .o_kick    (kick),
      .o_cs_n    (cs_n)
   );

   // ==========================================================
   // clock and slow timebase
   always #20 clk = ~clk;

   always @(negedge clk)
   begin
      ext_ph <= ~ext_ph;
      if (ext_run && ext_ph)
         ext_clk <= ~ext_clk;
   end

   // ==========================================================
   // checking
   task check(input string w, input logic e, input logic s);
      n_checks++;
      if (s !== e)
      begin
         num_errors++;
         $display("unexpected %s expected %b seen %b", w, e, s);
      end
   endtask

   task in_range(input string w, input int v, input int lo, input int hi);
      check(w, 1'b1, logic'(v >= lo && v <= hi));
   endtask

   task note(input int idx, input logic v);
      nt.idx = idx;
      nt.v   = v;
      q.push_back(nt);
   endtask

   task flush();
      -> sample_ev;
      #1;
   endtask

   always
   begin
      @(sample_ev);
      while (q.size() > 0)
      begin
         nt = q.pop_front();
         check(nm[nt.idx], nt.v, obs[nt.idx]);
      end
   end

   task finish_test();
      flush();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // ==========================================================
   // stimulus helpers
   task cyc(input int k);
      repeat (k) @(negedge clk);
   endtask

   // bounded wait; a limit that runs out ends the run
   task automatic wait_for(input int idx, input logic v, input int lim,
                           output int cnt);
      cnt = 0;
      while (obs[idx] !== v)
      begin
         @(negedge clk);
         cnt++;
         if (cnt > lim)
         begin
            num_errors++;
            $display("unexpected %s expected %b seen timeout", nm[idx], v);
            finish_test();
         end
      end
   endtask

   task pwr(input int off);
      sup_ok = 1'b0;
      cyc(off);
      sup_ok = 1'b1;
   endtask

   // ==========================================================
   // main sequence
   initial
   begin
      {clk, ext_ph, ext_clk, ext_run, kfl, cs_req} = 6'h00;
      {rst, sup_ok, abv_bat, pf_ok, sel, tbase, kick_en} = 7'h7f;
      num_errors = 0;
      n_checks   = 0;
      seed       = 80;
      cyc(5);
      rst = 1'b0;
      cyc(5);
      note(RSN, 1'b0);
      note(EN, 1'b0);
      note(CEO, 1'b1);
      note(ODO, 1'b0);
      flush();
      wait_for(RSN, 1'b1, RSTC + 40, n);
      in_range("rst_pulse", n + 5, RSTC - TCK, RSTC + TCK + 8);
      cyc(2);
      note(ODOE, 1'b1);
      note(EN, 1'b1);
      flush();
      // flags with random comparator levels
      repeat (8)
      begin
         r = $random(seed);
         abv_bat = r[0];
         pf_ok   = r[1];
         cyc(5);
         note(BK, ~r[0]);
         note(EF, r[1]);
         note(SL, 1'b1);
         note(RSN, 1'b1);
         flush();
      end
      {abv_bat, pf_ok} = 2'h3;
      for (int i = 0; i < 4; i++)
      begin
         cs_req = i[0];
         cyc(3);
         note(CEO, ~i[0]);
         flush();
      end
      // long watchdog, no kicks: repeated pulses
      kick_en = 1'b0;
      wait_for(RSN, 1'b0, LNG + 60, n);
      in_range("wd_long", n, LNG - 2 * TCK, LNG + 2 * TCK);
      note(WATCHDOG_EXPIRED_OUT, 1'b0);
      flush();
      wait_for(RSN, 1'b1, RSTC + 20, n);
      in_range("wd_pulse", n, RSTC - TCK, RSTC + TCK);
      wait_for(RSN, 1'b0, LNG + 60, n);
      in_range("wd_repeat", n, LNG - 2 * TCK, LNG + 2 * TCK);
      note(WATCHDOG_EXPIRED_OUT, 1'b0);
      flush();
      kick_en = 1'b1;
      wait_for(WATCHDOG_EXPIRED_OUT, 1'b1, 20, n);
      wait_for(RSN, 1'b1, RSTC + 20, n);
      // floating kick pin: watchdog off
      kfl     = 1'b1;
      kick_en = 1'b0;
      cyc(LNG + 40);
      note(RSN, 1'b1);
      note(WATCHDOG_EXPIRED_OUT, 1'b1);
      flush();
      kfl = 1'b0;
      // short watchdog: long first period, then short
      tbase = 1'b0;
      pwr(10);
      wait_for(RSN, 1'b1, RSTC + 40, n);
      in_range("short_rst", n, RSTC - TCK, RSTC + TCK + 8);
      wait_for(RSN, 1'b0, LNG + 60, n);
      in_range("first_per", n, LNG - 2 * TCK, LNG + 2 * TCK);
      wait_for(RSN, 1'b1, RSTC + 20, n);
      kick_en = 1'b1;
      cyc(3 * SHT);
      note(RSN, 1'b1);
      flush();
      kick_en = 1'b0;
      wait_for(RSN, 1'b0, LNG, n);
      in_range("short_per", n, SHT - 2 * TCK, SHT + 2 * TCK);
      kick_en = 1'b1;
      tbase   = 1'b1;
      wait_for(RSN, 1'b1, RSTC + 20, n);
      // power-down with a write in flight, ended by select going high
      cs_req = 1'b1;
      sup_ok = 1'b0;
      wait_for(RSN, 1'b0, 10, n);
      cyc(10);
      note(EN, 1'b1);
      note(CEO, 1'b0);
      flush();
      cs_req = 1'b0;
      cyc(4);
      note(EN, 1'b0);
      note(CEO, 1'b1);
      flush();
      cs_req = 1'b1;
      sup_ok = 1'b1;
      cyc(5);
      note(EN, 1'b0);
      note(CEO, 1'b1);
      flush();
      wait_for(RSN, 1'b1, RSTC + 40, n);
      cyc(3);
      note(EN, 1'b1);
      note(CEO, 1'b0);
      flush();
      // select held low: gate closes on the hold time
      sup_ok = 1'b0;
      wait_for(RSN, 1'b0, 10, n);
      cyc(srg_pkg::CE_HOLD_CYC - 30);
      note(EN, 1'b1);
      flush();
      cyc(40);
      note(EN, 1'b0);
      note(CEO, 1'b1);
      flush();
      cs_req = 1'b0;
      // backup needs both conditions
      cyc(5);
      note(HIZ, 1'b0);
      note(BK, 1'b0);
      flush();
      abv_bat = 1'b0;
      cyc(6);
      note(HIZ, 1'b1);
      note(BK, 1'b1);
      note(EF, 1'b0);
      note(WATCHDOG_EXPIRED_OUT, 1'b1);
      note(RSN, 1'b0);
      note(ODOE, 1'b0);
      note(SL, 1'b0);
      note(CEO, 1'b1);
      note(EN, 1'b0);
      flush();
      abv_bat = 1'b1;
      sup_ok  = 1'b1;
      wait_for(RSN, 1'b1, RSTC + 40, n);
      // external timebase: reset pulse counted in its clocks
      sel     = 1'b0;
      ext_run = 1'b1;
      cyc(8);
      pwr(10);
      wait_for(RSN, 1'b1, EXT + 200, n);
      in_range("ext_rst", n, EXT - 16, EXT + 40);
      finish_test();
   end
endmodule
